//--- npg_pkg.sv
// constants, types and field layout of the nine port pin bank
// Operation
// - nine ports mapped at indices ff0 to ff8
// - thirty six pins: 4 in, 24 io, 8 open-drain
// - latches readable, writable, testable per bit or wider
// - ports zero, two, three: per-pin direction
// - port zero group pull-up, off on outputs
// - input only port, data writes have no effect
// - input only port pull-ups on lower three pins
// - open-drain ports drive low or release only
// - open-drain ports pair into one byte
// - open-drain pull-ups fixed by build parameter
// - port six direction, pull-up, auto off outputs
// - ports six and seven pair into one byte
// - pulldown port per-pin direction
// - pulldown port group pull-down, off on outputs
package npg_pkg;
   localparam int NPG_PORTS = 9;
   localparam int NPG_PW = 4;
   // bus geometry: word index sits above the two byte bits
   localparam int NPG_ADR_W = 14;
   localparam int NPG_IDX_W = 12;
   localparam int NPG_IDX_LSB = 2;
   // register indices; byte address is four times the index
   localparam logic [11:0] NPG_DATA_BASE = 12'hff0;
   localparam logic [11:0] NPG_DATA_LAST = 12'hff8;
   localparam logic [11:0] NPG_PAIR_OD = 12'hffa;
   localparam logic [11:0] NPG_PAIR_KS = 12'hffb;
   localparam logic [11:0] NPG_CFG_BASE = 12'hfe0;
   localparam logic [11:0] NPG_CFG_LAST = 12'hfe8;
   // data word fields
   localparam int NPG_DAT_LSB = 0;
   localparam int NPG_MASK_LSB = 8;
   localparam int NPG_PAIR_HI_LSB = 4;
   // config word fields
   localparam int NPG_DIR_LSB = 0;
   localparam int NPG_RES_BIT = 4;
   // per-port capabilities, bit n for port n
   localparam logic [8:0] NPG_HAS_DIR = 9'h1cd;
   localparam logic [8:0] NPG_HAS_PU = 9'h04f;
   localparam logic [8:0] NPG_HAS_PD = 9'h100;
   localparam logic [8:0] NPG_IS_OD = 9'h030;
   localparam int NPG_IN_PORT = 1;
   localparam logic [3:0] NPG_IN_PU_PINS = 4'h7;
   localparam logic [3:0] NPG_ALL_PINS = 4'hf;
   localparam logic [3:0] NPG_NO_PINS = 4'h0;
   // reset values
   localparam logic [3:0] NPG_DIR_RST = 4'h0;
   localparam logic NPG_RES_RST = 1'b0;
   localparam logic [3:0] NPG_LATCH_RST = 4'hf;
   localparam logic [7:0] NPG_OD_PULL_DEF = 8'h00;

   typedef logic [8:0][3:0] npg_pins_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [13:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } npg_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } npg_wb_rsp_t;
endpackage

//--- npg_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module npg_pin_sync (
   input wire logic clk,                       // system clock
   input wire logic rst,                       // sync reset, high
   input wire npg_pkg::npg_pins_t pin_i,       // raw pad levels
   output var npg_pkg::npg_pins_t pin_s        // filtered levels
);
   import npg_pkg::*;

   typedef struct packed {
      npg_pins_t s1;
      npg_pins_t s2;
      npg_pins_t s3;
      npg_pins_t val;
   } npg_sync_st_t;

   npg_sync_st_t st_ff;
   npg_sync_st_t nxt_st;

   // s1 feeds only s2; a bit moves once s2 and s3 agree
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int p = 0; p < NPG_PORTS; p++) begin
         for (int b = 0; b < NPG_PW; b++) begin
            if (st_ff.s2[p][b] == st_ff.s3[p][b]) begin
               nxt_st.val[p][b] = st_ff.s3[p][b];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_s = st_ff.val;
endmodule
`default_nettype wire

//--- npg_port_drive.sv
// pad drive and resistor control for one four-pin port
`timescale 1ns/10ps
`default_nettype none
module npg_port_drive #(
   parameter bit IS_OD = 1'b0,                 // open-drain port
   parameter logic [3:0] PU_PINS = 4'h0,       // soft pull-up pins
   parameter logic [3:0] PD_PINS = 4'h0,       // soft pull-down pins
   parameter logic [3:0] FIXED_PU = 4'h0       // build-time pull-ups
) (
   input wire logic [3:0] latch,               // output latch
   input wire logic [3:0] dir,                 // 1 = output
   input wire logic res_en,                    // group resistor enable
   output logic [3:0] o,                       // pad output level
   output logic [3:0] oe,                      // pad drive enable
   output logic [3:0] pu,                      // pull-up enable
   output logic [3:0] pd                       // pull-down enable
);
   import npg_pkg::*;

   // open-drain pulls low on a zero latch, floats on a one
   always_comb begin
      if (IS_OD) begin
         o = NPG_NO_PINS;
         oe = ~latch;
         pu = FIXED_PU;
         pd = NPG_NO_PINS;
      end else begin
         o = latch;
         oe = dir;
         // resistors drop on any pin turned output
         pu = res_en ? (PU_PINS & ~dir) : NPG_NO_PINS;
         pd = res_en ? (PD_PINS & ~dir) : NPG_NO_PINS;
      end
   end
endmodule
`default_nettype wire

//--- npg_gpio_bank.sv
// nine port gpio bank with classic wishbone register access
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module npg_gpio_bank #(
   parameter logic [7:0] OD_PULL = npg_pkg::NPG_OD_PULL_DEF  // od pull-ups
) (
   input wire logic clk,                       // system clock
   input wire logic rst,                       // sync reset, high
   input wire npg_pkg::npg_wb_req_t wb_req,    // wishbone request
   output var npg_pkg::npg_wb_rsp_t wb_rsp,    // wishbone answer
   input wire npg_pkg::npg_pins_t pin_i,       // pad input levels
   output var npg_pkg::npg_pins_t pin_o,       // pad output levels
   output var npg_pkg::npg_pins_t pin_oe,      // pad drive enables
   output var npg_pkg::npg_pins_t pin_pu,      // pull-up enables
   output var npg_pkg::npg_pins_t pin_pd       // pull-down enables
);
   import npg_pkg::*;

   typedef struct packed {
      npg_wb_rsp_t rsp;
      npg_pins_t latch;
      npg_pins_t dir;
      logic [8:0] res_en;
      npg_pins_t o;
      npg_pins_t oe;
      npg_pins_t pu;
      npg_pins_t pd;
   } npg_bank_st_t;

   npg_bank_st_t st_ff;
   npg_bank_st_t nxt_st;
   npg_pins_t pin_s;
   npg_pins_t drv_o;
   npg_pins_t drv_oe;
   npg_pins_t drv_pu;
   npg_pins_t drv_pd;
   npg_pins_t pv;
   logic [11:0] idx;
   logic req;

   // pad inputs come from another domain, so filter them
   npg_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pin_i(pin_i),
      .pin_s(pin_s)
   );

   // one drive block per port, shaped by its capabilities
   generate
      for (genvar g = 0; g < NPG_PORTS; g++) begin : g_port
         localparam logic [3:0] PU_P = !NPG_HAS_PU[g] ? NPG_NO_PINS :
            (g == NPG_IN_PORT) ? NPG_IN_PU_PINS : NPG_ALL_PINS;
         localparam logic [3:0] PD_P = NPG_HAS_PD[g] ? NPG_ALL_PINS :
            NPG_NO_PINS;
         localparam logic [3:0] FX_P = (g == 4) ? OD_PULL[3:0] :
            (g == 5) ? OD_PULL[7:4] : NPG_NO_PINS;
         npg_port_drive #(
            .IS_OD(NPG_IS_OD[g]),
            .PU_PINS(PU_P),
            .PD_PINS(PD_P),
            .FIXED_PU(FX_P)
         ) u_drv (
            .latch(st_ff.latch[g]),
            .dir(st_ff.dir[g]),
            .res_en(st_ff.res_en[g]),
            .o(drv_o[g]),
            .oe(drv_oe[g]),
            .pu(drv_pu[g]),
            .pd(drv_pd[g])
         );
      end
   endgenerate

   // value seen by a read or test: latch on outputs, pad on inputs and on open-drain ports
   always_comb begin
      for (int p = 0; p < NPG_PORTS; p++) begin
         if (NPG_IS_OD[p]) begin
            pv[p] = pin_s[p];
         end else begin
            pv[p] = (st_ff.dir[p] & st_ff.latch[p]) |
               (~st_ff.dir[p] & pin_s[p]);
         end
      end
   end

   assign idx = wb_req.adr[NPG_ADR_W-1:NPG_IDX_LSB];
   // one answer per request; ack drops the cycle after
   assign req = wb_req.cyc & wb_req.stb & ~st_ff.rsp.ack;

   // register decode, write effects and answer
   always_comb begin
      logic [3:0] pidx;
      logic [3:0] m;
      logic [3:0] wd;
      logic wr;
      pidx = 4'h0;
      m = NPG_ALL_PINS;
      wd = wb_req.dat[NPG_DAT_LSB +: NPG_PW];
      wr = req & wb_req.we & wb_req.sel[0];
      nxt_st = st_ff;
      nxt_st.rsp.ack = req;
      nxt_st.rsp.dat = '0;
      // a zero mask means a full four-bit access
      if (wb_req.dat[NPG_MASK_LSB +: NPG_PW] != NPG_NO_PINS) begin
         m = wb_req.dat[NPG_MASK_LSB +: NPG_PW];
      end
      if (idx >= NPG_DATA_BASE && idx <= NPG_DATA_LAST) begin
         pidx = 4'(idx - NPG_DATA_BASE);
         if (req) begin
            nxt_st.rsp.dat[NPG_DAT_LSB +: NPG_PW] = pv[pidx];
         end
         // the input-only port keeps no output latch
         if (wr && pidx != 4'(NPG_IN_PORT)) begin
            nxt_st.latch[pidx] = (st_ff.latch[pidx] & ~m) | (wd & m);
         end
      end else if (idx == NPG_PAIR_OD) begin
         if (req) begin
            nxt_st.rsp.dat[7:0] = {pv[5], pv[4]};
         end
         if (wr) begin
            nxt_st.latch[4] = wb_req.dat[NPG_DAT_LSB +: NPG_PW];
            nxt_st.latch[5] = wb_req.dat[NPG_PAIR_HI_LSB +: NPG_PW];
         end
      end else if (idx == NPG_PAIR_KS) begin
         if (req) begin
            nxt_st.rsp.dat[7:0] = {pv[7], pv[6]};
         end
         if (wr) begin
            nxt_st.latch[6] = wb_req.dat[NPG_DAT_LSB +: NPG_PW];
            nxt_st.latch[7] = wb_req.dat[NPG_PAIR_HI_LSB +: NPG_PW];
         end
      end else if (idx >= NPG_CFG_BASE && idx <= NPG_CFG_LAST) begin
         pidx = 4'(idx - NPG_CFG_BASE);
         if (req) begin
            nxt_st.rsp.dat[NPG_DIR_LSB +: NPG_PW] = st_ff.dir[pidx];
            nxt_st.rsp.dat[NPG_RES_BIT] = st_ff.res_en[pidx];
         end
         // fields a port lacks stay at zero
         if (wr && NPG_HAS_DIR[pidx]) begin
            nxt_st.dir[pidx] = wb_req.dat[NPG_DIR_LSB +: NPG_PW];
         end
         if (wr && (NPG_HAS_PU[pidx] || NPG_HAS_PD[pidx])) begin
            nxt_st.res_en[pidx] = wb_req.dat[NPG_RES_BIT];
         end
      end
      // pads follow one cycle behind the latches, from flops
      nxt_st.o = drv_o;
      nxt_st.oe = drv_oe;
      nxt_st.pu = drv_pu;
      nxt_st.pd = drv_pd;
   end

   // reset: all pins inputs, resistors off, latches high
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff.rsp <= '0;
         st_ff.latch <= {NPG_PORTS{NPG_LATCH_RST}};
         st_ff.dir <= {NPG_PORTS{NPG_DIR_RST}};
         st_ff.res_en <= {NPG_PORTS{NPG_RES_RST}};
         st_ff.o <= '0;
         st_ff.oe <= '0;
         st_ff.pu <= '0;
         st_ff.pd <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_rsp = st_ff.rsp;
   assign pin_o = st_ff.o;
   assign pin_oe = st_ff.oe;
   assign pin_pu = st_ff.pu;
   assign pin_pd = st_ff.pd;
endmodule
`default_nettype wire

//--- npg_asserts.sv
// port-level checker for the nine port gpio bank
`timescale 1ns/10ps
`default_nettype none
module npg_asserts #(
   parameter logic [7:0] OD_PULL = 8'h00 // od pull-ups
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   input wire npg_pkg::npg_wb_req_t wb_req, // bus request
   input wire npg_pkg::npg_wb_rsp_t wb_rsp, // bus answer
   input wire npg_pkg::npg_pins_t pin_o, // pad levels
   input wire npg_pkg::npg_pins_t pin_oe, // drive enables
   input wire npg_pkg::npg_pins_t pin_pu, // pull-ups
   input wire npg_pkg::npg_pins_t pin_pd // pull-downs
);
   import npg_pkg::*;
   logic go;
   // request taken on this edge
   assign go = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_ack_after_take: assert property (go |=> wb_rsp.ack)
      else $error("request not acked next cycle");
   chk_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held too long");
   chk_dat_idle_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
      else $error("read data outside ack");
   chk_od_never_high: assert property (pin_o[4] == 4'h0 && pin_o[5] == 4'h0)
      else $error("open-drain pad driven high");
   chk_in_port_quiet: assert property (pin_oe[1] == 4'h0 && !pin_pu[1][3])
      else $error("input port drives or pulls top pin");
   chk_pu_gate_out: assert property ((pin_pu[0] & pin_oe[0]) == 4'h0 &&
      (pin_pu[6] & pin_oe[6]) == 4'h0) else $error("pull-up on output pin");
   chk_pd_gate_out: assert property ((pin_pd[8] & pin_oe[8]) == 4'h0 &&
      pin_pd[7:0] == '0) else $error("pull-down misplaced");
   chk_od_pull_fixed: assert property (!$past(rst) |->
      {pin_pu[5], pin_pu[4]} == OD_PULL) else $error("od pull-ups not fixed");
   chk_od_pair_write: assert property (go && wb_req.we && wb_req.sel[0] &&
      wb_req.adr[13:2] == NPG_PAIR_OD |-> ##2 {pin_oe[5], pin_oe[4]} ==
      ~$past(wb_req.dat[7:0], 2)) else $error("od pair write lost");
   chk_release_clear: assert property ($fell(rst) |=>
      pin_oe == '0 && pin_pd == '0) else $error("drive left after reset");
endmodule
bind npg_gpio_bank npg_asserts #(.OD_PULL(OD_PULL)) i_chk (.clk(clk), .rst(rst),
   .wb_req(wb_req), .wb_rsp(wb_rsp), .pin_o(pin_o), .pin_oe(pin_oe),
   .pin_pu(pin_pu), .pin_pd(pin_pd));
`default_nettype wire

//--- npg_pads.sv
// pad model: far-side drivers, resistors and floating pins
`timescale 1ns/10ps
`default_nettype none
module npg_pads (
   input wire logic clk, // system clock
   input wire npg_pkg::npg_pins_t o, // bank levels
   input wire npg_pkg::npg_pins_t oe, // bank enables
   input wire npg_pkg::npg_pins_t pu, // pull-ups
   input wire npg_pkg::npg_pins_t pd, // pull-downs
   input wire npg_pkg::npg_pins_t ext, // far drive level
   input wire npg_pkg::npg_pins_t ext_en, // far drive on
   output var npg_pkg::npg_pins_t pad // resolved level
);
   import npg_pkg::*;
   logic flt_ff = 1'b0;
   // unpulled free pins wander, so a stale level never reads valid
   always @(posedge clk) flt_ff <= ~flt_ff;
   // bank drive first (od ports only ever drive low), then far side, pulls
   always_comb begin
      for (int p = 0; p < 9; p++) begin
         for (int b = 0; b < 4; b++) begin
            if (oe[p][b]) pad[p][b] = o[p][b];
            else if (ext_en[p][b]) pad[p][b] = ext[p][b];
            else if (pu[p][b]) pad[p][b] = 1'b1;
            else if (pd[p][b]) pad[p][b] = 1'b0;
            else pad[p][b] = flt_ff;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the nine port gpio bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch %0t at line %0d", $time, `__LINE__); end end
module tb_top;
   import npg_pkg::*;
   logic clk, rst;
   npg_wb_req_t req;
   npg_wb_rsp_t rsp;
   npg_pins_t pad, po, poe, ppu, ppd, ext, ext_en;
   logic [31:0] q;
   int err_count, num_checks, cyc_n;
   npg_gpio_bank #(.OD_PULL(8'hff)) i_dut (.clk(clk), .rst(rst), .wb_req(req),
      .wb_rsp(rsp), .pin_i(pad), .pin_o(po), .pin_oe(poe), .pin_pu(ppu), .pin_pd(ppd));
   npg_pads i_pads (.clk(clk), .o(po), .oe(poe), .pu(ppu), .pd(ppd), .ext(ext),
      .ext_en(ext_en), .pad(pad));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the under two hundred cycles used
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         err_count++;
         $display("mismatch %0t cycle limit reached", $time);
         print_verdict;
      end
   end
   // one classic cycle; ack and data taken on the edge ack is seen
   // no wait state is assumed; only the cycle limit ends a stuck wait
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d);
      req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: {idx, 2'h0}, sel: 4'hf, dat: d};
      do @(posedge clk); while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge clk);
   endtask
   // out of reset: inputs only, config clear, unmapped reads zero
   task automatic t_reset;
      `CHK(poe, '0)
      `CHK(ppd, '0)
      `CHK(ppu, {12'h0, 8'hff, 16'h0})
      for (int p = 0; p < 9; p++) begin
         bus(1'b0, 12'hfe0 + 12'(p), 32'h0);
         `CHK(q, 32'h0)
      end
      bus(1'b0, 12'hfff, 32'h0);
      `CHK(q, 32'h0)
   endtask
   // per-pin direction; reads mix latch on outputs with pad on inputs
   task automatic t_dir;
      int ports[6] = '{0, 2, 3, 6, 7, 8};
      foreach (ports[i]) begin
         bus(1'b1, 12'hfe0 + 12'(ports[i]), 32'ha);
         bus(1'b1, 12'hff0 + 12'(ports[i]), 32'h6);
         `CHK(poe[ports[i]], 4'ha)
         `CHK(po[ports[i]] & 4'ha, 4'h2)
         bus(1'b0, 12'hff0 + 12'(ports[i]), 32'h0);
         `CHK(q[3:0], 4'h2 | (ext[ports[i]] & 4'h5))
      end
      bus(1'b1, 12'hff0, 32'h200);
      `CHK(po[0] & 4'ha, 4'h0)
      bus(1'b1, 12'hfe1, 32'hf);
      bus(1'b1, 12'hff1, 32'h0);
      `CHK(poe[1], 4'h0)
      bus(1'b0, 12'hff1, 32'h0);
      `CHK(q[3:0], ext[1])
      bus(1'b1, 12'hffb, 32'h5a);
      `CHK({po[7], po[6]} & 8'haa, 8'h0a)
   endtask
   // group resistors, switched off where a pin drives
   task automatic t_pull;
      for (int p = 0; p < 9; p++) bus(1'b1, 12'hfe0 + 12'(p), 32'h13);
      `CHK(ppu[0], 4'hc)
      `CHK(ppu[1], 4'h7)
      `CHK(ppu[6], 4'hc)
      `CHK(ppu[7], 4'h0)
      `CHK(ppd[8], 4'hc)
      `CHK(ppu[5:4], 8'hff)
      `CHK({poe[8:6], poe[3:2], poe[0]}, 24'h333333)
      `CHK(poe[1], 4'h0)
   endtask
   // second reset in mid-run: config and drive must fall back
   task automatic t_rerst;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(poe, '0)
      `CHK(ppd, '0)
      `CHK(ppu, {12'h0, 8'hff, 16'h0})
      bus(1'b0, 12'hfe8, 32'h0);
      `CHK(q, 32'h0)
   endtask
   // open-drain pair: low or released; released pins read pulled high
   task automatic t_od;
      ext_en[5:4] <= '0;
      bus(1'b1, 12'hffa, 32'h3c);
      `CHK({poe[5], poe[4]}, 8'hc3)
      `CHK({po[5], po[4]}, 8'h00)
      repeat (5) @(posedge clk);
      bus(1'b0, 12'hffa, 32'h0);
      `CHK(q[7:0], 8'h3c)
      bus(1'b1, 12'hff4, 32'h400);
      repeat (5) @(posedge clk);
      bus(1'b0, 12'hff4, 32'h0);
      `CHK(q[3:0], 4'h8)
   endtask
   initial begin
      rst = 1'b1;
      req = '0;
      ext = {9{4'h9}};
      ext_en = '1;
      err_count = 0;
      num_checks = 0;
      cyc_n = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset;
      t_dir;
      t_pull;
      t_od;
      t_rerst;
      print_verdict;
   end
endmodule
`default_nettype wire
